/* dv/lvi_cpu_model.sv */
// cpu side stand-in: takes the supply vector after lat_i cycles, returns later
module lvi_cpu_model (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       vec_i,
    input  wire logic [3:0] lat_i,
    output logic            service_o,
    output logic      [4:0] group_o,
    output logic            interrupt_return_instr_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt_r;
    logic       busy_r;
    // only the supply group flag is cleared on entry, the source flag is left alone
    assign group_o = 5'h02;
    always @(posedge clk_i) begin
        service_o <= 1'b0;
        interrupt_return_instr_o    <= 1'b0;
        if (rst_i) begin
            busy_r <= 1'b0;
            cnt_r  <= 4'h0;
        end else if (busy_r) begin
            cnt_r <= cnt_r + 4'h1;
            if (cnt_r == 4'h6) begin
                interrupt_return_instr_o <= 1'b1;
                busy_r <= 1'b0;
                cnt_r  <= 4'h0;
            end
        end else if (vec_i) begin
            cnt_r <= cnt_r + 4'h1;
            if (cnt_r == lat_i) begin
                service_o <= 1'b1;
                busy_r    <= 1'b1;
                cnt_r     <= 4'h0;
            end
        end else begin
            // a vector that goes away before it is taken restarts the latency count
            cnt_r <= 4'h0;
        end
    end
endmodule

/* dv/lvi_top_asserts.sv */
// concurrent checks on the supply monitor control block ports
module lvi_top_asserts #(
    parameter int DELAY_CYC = 4
) (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [7:0]  adr_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    input wire logic        cmp_i,
    input wire logic        sleep_i,
    input wire logic        stack_full_i,
    input wire logic        service_i,
    input wire logic        det_pwr_o,
    input wire logic        ref_en_o,
    input wire logic [2:0]  threshold_o,
    input wire logic        vector_req_o,
    input wire logic        push_pc_o,
    input wire logic        wake_o,
    input wire logic        irq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // ========================================================
    // bus handshake
    ack_once_a: assert property (ack_o |=> !ack_o) else $error("ack held too long");
    ack_lat_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack missing");
    // ========================================================
    // register and outputs
    ctrl_zero_a: assert property (
        cyc_i && stb_i && !ack_o && !we_i && adr_i == lvi_pkg::ADR_CTRL |=> dat_o[7:6] == 2'h0 && !dat_o[3])
        else $error("unused control bits not zero");
    flag_low_a: assert property (
        (!cmp_i) [*4] ##0 (cyc_i && stb_i && !ack_o && !we_i && adr_i == lvi_pkg::ADR_CTRL) |=> !dat_o[5])
        else $error("low flag set with supply good");
    ref_pwr_a: assert property (ref_en_o == det_pwr_o) else $error("reference not tied to detector");
    push_pulse_a: assert property (service_i |=> push_pc_o ##1 !push_pc_o) else $error("pc push wrong");
    vec_full_a: assert property (stack_full_i |=> !vector_req_o) else $error("vector with full stack");
    wake_sleep_a: assert property (wake_o |-> $past(sleep_i)) else $error("wake outside sleep");
    rst_clear_a: assert property (
        $fell(rst_i) |-> threshold_o == 3'h0 && !det_pwr_o && !irq_o && !vector_req_o)
        else $error("outputs not cleared by reset");
endmodule

bind lvi_top lvi_top_asserts #(.DELAY_CYC(DELAY_CYC)) u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .dat_o(dat_o), .ack_o(ack_o), .cmp_i(cmp_i), .sleep_i(sleep_i), .stack_full_i(stack_full_i),
    .service_i(service_i), .det_pwr_o(det_pwr_o), .ref_en_o(ref_en_o), .threshold_o(threshold_o),
    .vector_req_o(vector_req_o), .push_pc_o(push_pc_o), .wake_o(wake_o), .irq_o(irq_o));

/* dv/tb_low_voltage_detect_irq.sv */
// self-checking bench for the supply monitor control block
module tb_low_voltage_detect_irq;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DLY = 4;
    typedef struct {string n; logic [31:0] v;} lvi_exp_t;
    logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic        cmp_i = 1'b0, sleep_i = 1'b0, stack_full_i = 1'b0;
    logic [7:0]  adr_i = 8'h00;
    logic [3:0]  sel_i = 4'h1, lat = 4'h0;
    logic [4:0]  group_evt_i = 5'h00, service_group_i;
    logic [31:0] dat_i = 32'h0000_0000, dat_o, rnd;
    logic        ack_o, service_i, interrupt_return_instr_i, det_pwr_o, ref_en_o, vector_req_o, push_pc_o, wake_o, irq_o;
    logic [2:0]  threshold_o;
    int          err_count = 0, samples_checked = 0, wake_n = 0, push_n = 0;
    lvi_exp_t    exp_q[$];
    lvi_exp_t    x;

    always #12.5 clk_i = ~clk_i;

    lvi_top #(.DELAY_CYC(DLY)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .cmp_i(cmp_i), .sleep_i(sleep_i), .stack_full_i(stack_full_i), .service_i(service_i),
        .service_group_i(service_group_i), .interrupt_return_instr_i(interrupt_return_instr_i), .group_evt_i(group_evt_i),
        .det_pwr_o(det_pwr_o), .ref_en_o(ref_en_o), .threshold_o(threshold_o),
        .vector_req_o(vector_req_o), .push_pc_o(push_pc_o), .wake_o(wake_o), .irq_o(irq_o));
    lvi_cpu_model u_cpu (.clk_i(clk_i), .rst_i(rst_i), .vec_i(vector_req_o), .lat_i(lat),
        .service_o(service_i), .group_o(service_group_i), .interrupt_return_instr_o(interrupt_return_instr_i));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic test_done;
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // one classic cycle; upper data bits carry noise the block must ignore
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
        int k;
        rnd = lfsr(rnd);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        dat_i <= {rnd[31:8], d};
        if (!w) exp_q.push_back('{$sformatf("reg %h", a), {24'h00_0000, e}});
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (ack_o !== 1'b1 && k < 20);
        if (k >= 20) begin
            err_count++;
            test_done();
        end
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask

    always @(posedge clk_i) begin
        if (wake_o === 1'b1) wake_n++;
        if (push_pc_o === 1'b1) push_n++;
        if (ack_o === 1'b1 && we_i === 1'b0 && exp_q.size() > 0) begin
            x = exp_q.pop_front();
            chk(x.n, dat_o, x.v);
        end
    end

    initial begin
        rnd = 32'h0001_5D5D; // seed 89437
        lat <= rnd[3:0];
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(0, lvi_pkg::ADR_CTRL, 8'h00, 8'h00);
        bus(0, lvi_pkg::ADR_IRQ_CTL, 8'h00, 8'h00);
        for (int t = 0; t < 8; t++) begin
            bus(1, lvi_pkg::ADR_CTRL, {rnd[7:6], 2'b11, rnd[3], t[2:0]}, 8'h00);
            bus(0, lvi_pkg::ADR_CTRL, 8'h00, {5'h02, t[2:0]});
            chk("threshold", {29'h0, threshold_o}, t);
            chk("power", {30'h0, det_pwr_o, ref_en_o}, 32'h0000_0003);
        end
        for (int i = 0; i < 3; i++) begin
            cmp_i <= ~i[0];
            repeat (4) @(posedge clk_i);
            bus(0, lvi_pkg::ADR_CTRL, 8'h00, i[0] ? 8'h17 : 8'h37);
        end
        bus(1, lvi_pkg::ADR_CTRL, 8'h00, 8'h00);
        bus(0, lvi_pkg::ADR_CTRL, 8'h00, 8'h00);
        chk("power off", {30'h0, det_pwr_o, ref_en_o}, 32'h0000_0000);
        cmp_i <= 1'b0;
        bus(1, lvi_pkg::ADR_CTRL, 8'h10, 8'h00);
        // the toggle runs above already fired the delay: clear what they left behind
        bus(1, lvi_pkg::ADR_GROUP, 8'h1F, 8'h00);
        bus(1, lvi_pkg::ADR_STATUS, 8'h03, 8'h00);
        bus(1, lvi_pkg::ADR_MASK, 8'h01, 8'h00);
        bus(1, lvi_pkg::ADR_IRQ_CTL, 8'h03, 8'h00);
        stack_full_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        chk("irq idle", {31'h0, irq_o}, 32'h0000_0000);
        cmp_i <= 1'b1;
        bus(0, lvi_pkg::ADR_IRQ_CTL, 8'h00, 8'h03);
        repeat (DLY + 8) @(posedge clk_i);
        bus(0, lvi_pkg::ADR_IRQ_CTL, 8'h00, 8'h07);
        chk("irq", {31'h0, irq_o}, 32'h0000_0001);
        chk("vector full", {31'h0, vector_req_o}, 32'h0000_0000);
        stack_full_i <= 1'b0;
        repeat (40) @(posedge clk_i);
        bus(0, lvi_pkg::ADR_IRQ_CTL, 8'h00, 8'h07);
        bus(0, lvi_pkg::ADR_GROUP, 8'h00, 8'h00);
        chk("pc pushes", push_n, 32'h0000_0001);
        cmp_i <= 1'b0;
        bus(1, lvi_pkg::ADR_STATUS, 8'h01, 8'h00);
        bus(1, lvi_pkg::ADR_IRQ_CTL, 8'h00, 8'h00);
        bus(0, lvi_pkg::ADR_IRQ_CTL, 8'h00, 8'h00);
        chk("irq clear", {31'h0, irq_o}, 32'h0000_0000);
        sleep_i <= 1'b1;
        cmp_i <= 1'b1;
        repeat (DLY + 8) @(posedge clk_i);
        chk("wake", wake_n, 32'h0000_0001);
        bus(0, lvi_pkg::ADR_STATUS, 8'h00, 8'h03);
        sleep_i <= 1'b0;
        cmp_i <= 1'b0;
        bus(1, lvi_pkg::ADR_GROUP, 8'h1F, 8'h00);
        bus(1, lvi_pkg::ADR_IRQ_CTL, 8'h04, 8'h00);
        group_evt_i <= 5'h02;
        @(posedge clk_i);
        group_evt_i <= 5'h00;
        sleep_i <= 1'b1;
        cmp_i <= 1'b1;
        repeat (DLY + 8) @(posedge clk_i);
        chk("preset wake", wake_n, 32'h0000_0001);
        bus(0, lvi_pkg::ADR_GROUP, 8'h00, 8'h02);
        test_done();
    end
endmodule

/* verilog/lvi_delay.sv */
// comparator synchroniser and irq set delay counter
module lvi_delay #(
    parameter int DELAY_CYC = lvi_pkg::IRQ_SET_DELAY_CYC
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic cmp_i,
    lvi_dly_if.dly    dly
);

    localparam int CW = $clog2(DELAY_CYC + 1);
    localparam logic [CW-1:0] LAST = CW'(DELAY_CYC - 1);

    typedef struct packed {
        logic          sync1;
        logic          sync2;
        logic          prev;
        logic          armed;
        logic [CW-1:0] cnt;
        logic          fire;
    } lvi_dly_state_t;

    lvi_dly_state_t s_r;
    lvi_dly_state_t s_nxt;

    // ========================================================
    // next state
    always_comb begin
        s_nxt       = s_r;
        s_nxt.sync1 = cmp_i;
        s_nxt.sync2 = s_r.sync1;
        // no filter: every edge of the synced level counts
        s_nxt.prev  = s_r.sync2;
        s_nxt.fire  = 1'b0;
        if (!dly.det_on || !s_r.sync2) begin
            // a low that ends before the delay raises nothing
            s_nxt.armed = 1'b0;
        end else if (!s_r.prev) begin
            s_nxt.armed = 1'b1;
            s_nxt.cnt   = '0;
        end else if (s_r.armed) begin
            if (s_r.cnt == LAST) begin
                s_nxt.fire  = 1'b1;
                s_nxt.armed = 1'b0;
            end else begin
                s_nxt.cnt = s_r.cnt + CW'(1);
            end
        end
    end

    // ========================================================
    // state register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign dly.flag_sync = s_r.sync2;
    assign dly.fire      = s_r.fire;

endmodule

/* verilog/lvi_dly_if.sv */
// carrier between the register block and the irq delay unit
interface lvi_dly_if;
    logic det_on;
    logic flag_sync;
    logic fire;

    modport ctl (
        output det_on,
        input  flag_sync,
        input  fire
    );

    modport dly (
        input  det_on,
        output flag_sync,
        output fire
    );
endinterface

/* verilog/lvi_pkg.sv */
// constants shared by the supply monitor control and its delay unit
package lvi_pkg;

    // ========================================================
    // timing
    localparam int CLK_PERIOD_NS     = 25;
    localparam int IRQ_SET_DELAY_NS  = 15000;
    localparam int IRQ_SET_DELAY_CYC = (IRQ_SET_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ========================================================
    // register byte offsets
    localparam logic [7:0] ADR_CTRL    = 8'h00;
    localparam logic [7:0] ADR_IRQ_CTL = 8'h04;
    localparam logic [7:0] ADR_GROUP   = 8'h08;
    localparam logic [7:0] ADR_STATUS  = 8'h0C;
    localparam logic [7:0] ADR_MASK    = 8'h10;

    // ========================================================
    // field positions
    localparam int CTRL_FLAG_BIT    = 5;
    localparam int CTRL_ON_BIT      = 4;
    localparam int THR_LSB          = 0;
    localparam int THR_W            = 3;
    localparam int IEN_BIT          = 0;
    localparam int GIE_BIT          = 1;
    localparam int SFLAG_BIT        = 2;
    localparam int GROUP_W          = 5;
    localparam int GROUP_LSB        = 0;
    localparam int SUPPLY_GROUP_BIT = 1;
    localparam int ST_SUPPLY_BIT    = 0;
    localparam int ST_WAKE_BIT      = 1;
    localparam int ST_W             = 2;

    // ========================================================
    // values after reset
    localparam logic             DET_ON_RST = 1'b0;
    localparam logic [THR_W-1:0] THR_RST    = 3'h0;
    localparam logic             IEN_RST    = 1'b0;
    localparam logic             GIE_RST    = 1'b0;
    localparam logic             SFLAG_RST  = 1'b0;
    localparam logic [GROUP_W-1:0] GROUP_RST = 5'h00;
    localparam logic [ST_W-1:0]  STATUS_RST = 2'h0;
    localparam logic [ST_W-1:0]  MASK_RST   = 2'h0;

endpackage

/* verilog/lvi_top.sv */
// supply monitor control register, irq flag and wake logic
//
// What this block does
// - bit 5 of control reads high while supply sits below threshold and detector_on bit 4 is set.
// - detector_on bit 4 powers the detector; zero switches it off.
// - three-bit threshold field stored; every code means the same 3.6V level.
// - control bits 7, 6 and 3 read as zero.
// - reference enable follows detector use automatically.
// - flag follows comparator edges unfiltered, even when it toggles.
// - irq request flag sets a fixed delay after flag rises.
// - detector keeps running in sleep; a drop still sets the irq flag.
// - any request flag rising wakes sleep, enables ignored.
// - a set request flag stays until serviced or cleared by software.
// - service clears only group flags; source flag needs a software clear.
// - interrupt entry pushes only the program counter.
// - interrupt return sets global enable again.
// - plain return leaves global enable cleared.
// - vector branch needs global enable, source enable and stack not full.
module lvi_top #(
    parameter int DELAY_CYC = lvi_pkg::IRQ_SET_DELAY_CYC
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    input  wire logic        cmp_i,
    input  wire logic        sleep_i,
    input  wire logic        stack_full_i,
    input  wire logic        service_i,
    input  wire logic [4:0]  service_group_i,
    input  wire logic        interrupt_return_instr_i,
    input  wire logic [4:0]  group_evt_i,
    output logic             det_pwr_o,
    output logic             ref_en_o,
    output logic      [2:0]  threshold_o,
    output logic             vector_req_o,
    output logic             push_pc_o,
    output logic             wake_o,
    output logic             irq_o
);

    localparam int GW = lvi_pkg::GROUP_W;
    localparam int SW = lvi_pkg::ST_W;
    localparam int TW = lvi_pkg::THR_W;

    typedef struct packed {
        logic          ack;
        logic [31:0]   rdata;
        logic          det_on;
        logic [TW-1:0] thr;
        logic          ien;
        logic          gie;
        logic          sflag;
        logic [GW-1:0] group;
        logic [SW-1:0] status;
        logic [SW-1:0] mask;
        logic          vreq;
        logic          push;
        logic          wake;
        logic          irq;
    } lvi_state_t;

    lvi_state_t s_r;
    lvi_state_t s_nxt;

    lvi_dly_if dly_bus ();

    // ========================================================
    // delay unit
    lvi_delay #(
        .DELAY_CYC (DELAY_CYC)
    ) u_delay (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .cmp_i (cmp_i),
        .dly   (dly_bus.dly)
    );

    // detector stays on through sleep; the det_on path never looks at sleep_i
    assign dly_bus.det_on = s_r.det_on;

    // ========================================================
    // read decode
    function automatic logic [31:0] rd_word(
        input logic [7:0] adr,
        input lvi_state_t s,
        input logic       low
    );
        logic [31:0] w;
        w = '0;
        unique case (adr)
            lvi_pkg::ADR_CTRL: begin
                // bits 7, 6 and 3 stay zero
                w[lvi_pkg::CTRL_FLAG_BIT] = low;
                w[lvi_pkg::CTRL_ON_BIT]   = s.det_on;
                w[lvi_pkg::THR_LSB +: TW] = s.thr;
            end
            lvi_pkg::ADR_IRQ_CTL: begin
                w[lvi_pkg::IEN_BIT]   = s.ien;
                w[lvi_pkg::GIE_BIT]   = s.gie;
                w[lvi_pkg::SFLAG_BIT] = s.sflag;
            end
            lvi_pkg::ADR_GROUP: begin
                w[lvi_pkg::GROUP_LSB +: GW] = s.group;
            end
            lvi_pkg::ADR_STATUS: begin
                w[SW-1:0] = s.status;
            end
            lvi_pkg::ADR_MASK: begin
                w[SW-1:0] = s.mask;
            end
            default: begin
                // unmapped offsets answer with zero
                w = '0;
            end
        endcase
        return w;
    endfunction

    // ========================================================
    // next state
    logic       req;
    logic       wr;
    logic [7:0] wd;
    logic       low;
    logic       rise;

    always_comb begin
        s_nxt      = s_r;
        s_nxt.ack  = 1'b0;
        s_nxt.push = 1'b0;
        s_nxt.wake = 1'b0;

        // ack drops the cycle after it is given, so one request, one ack
        req = cyc_i && stb_i && !s_r.ack;
        wr  = req && we_i && sel_i[0];
        wd  = dat_i[7:0];

        // meaningless while the detector is unpowered, so masked there
        low = dly_bus.flag_sync && s_r.det_on;

        // ----------------------------------------------------
        // bus answer
        if (req) begin
            s_nxt.ack   = 1'b1;
            s_nxt.rdata = rd_word(adr_i, s_r, low);
        end

        // ----------------------------------------------------
        // software writes
        if (wr) begin
            unique case (adr_i)
                lvi_pkg::ADR_CTRL: begin
                    s_nxt.det_on = wd[lvi_pkg::CTRL_ON_BIT];
                    // all codes give one level; kept for read back
                    s_nxt.thr = wd[lvi_pkg::THR_LSB +: TW];
                end
                lvi_pkg::ADR_IRQ_CTL: begin
                    s_nxt.ien = wd[lvi_pkg::IEN_BIT];
                    s_nxt.gie = wd[lvi_pkg::GIE_BIT];
                    // a write of one pre-sets the flag; a supply drop still wakes unless supply group bit 1 is set too
                    s_nxt.sflag = wd[lvi_pkg::SFLAG_BIT];
                end
                lvi_pkg::ADR_GROUP: begin
                    s_nxt.group = s_r.group & ~wd[lvi_pkg::GROUP_LSB +: GW];
                end
                lvi_pkg::ADR_STATUS: begin
                    s_nxt.status = s_r.status & ~wd[SW-1:0];
                end
                lvi_pkg::ADR_MASK: begin
                    s_nxt.mask = wd[SW-1:0];
                end
                default: begin
                    s_nxt.mask = s_nxt.mask;
                end
            endcase
        end

        // ----------------------------------------------------
        // interrupt entry and return
        if (service_i) begin
            s_nxt.gie = 1'b0;
            // only the program counter goes to the stack
            s_nxt.push = 1'b1;
            // group flags clear; the source flag sflag is left alone
            s_nxt.group = s_nxt.group & ~service_group_i;
        end
        // besides a software write, gie is raised only here, so a plain return leaves it low
        if (interrupt_return_instr_i) begin
            s_nxt.gie = 1'b1;
        end

        // ----------------------------------------------------
        // hardware sets win over any clear in the same cycle
        s_nxt.group = s_nxt.group | group_evt_i;
        if (dly_bus.fire) begin
            s_nxt.sflag = 1'b1;
            s_nxt.group[lvi_pkg::SUPPLY_GROUP_BIT] = 1'b1;
            s_nxt.status[lvi_pkg::ST_SUPPLY_BIT]   = 1'b1;
        end

        // ----------------------------------------------------
        // wake on any request flag going high, enables not looked at
        rise = |({s_nxt.sflag, s_nxt.group} & ~{s_r.sflag, s_r.group});
        if (sleep_i && rise) begin
            s_nxt.wake = 1'b1;
            s_nxt.status[lvi_pkg::ST_WAKE_BIT] = 1'b1;
        end

        // ----------------------------------------------------
        // vector branch request
        s_nxt.vreq = s_nxt.gie && s_nxt.ien && !stack_full_i &&
                     s_nxt.group[lvi_pkg::SUPPLY_GROUP_BIT];

        s_nxt.irq = |(s_nxt.status & s_nxt.mask);
    end

    // ========================================================
    // state register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_r.ack    <= 1'b0;
            s_r.rdata  <= '0;
            s_r.det_on <= lvi_pkg::DET_ON_RST;
            s_r.thr    <= lvi_pkg::THR_RST;
            s_r.ien    <= lvi_pkg::IEN_RST;
            s_r.gie    <= lvi_pkg::GIE_RST;
            s_r.sflag  <= lvi_pkg::SFLAG_RST;
            s_r.group  <= lvi_pkg::GROUP_RST;
            s_r.status <= lvi_pkg::STATUS_RST;
            s_r.mask   <= lvi_pkg::MASK_RST;
            s_r.vreq   <= 1'b0;
            s_r.push   <= 1'b0;
            s_r.wake   <= 1'b0;
            s_r.irq    <= 1'b0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ========================================================
    // outputs, each straight from a flop
    assign dat_o        = s_r.rdata;
    assign ack_o        = s_r.ack;
    assign det_pwr_o    = s_r.det_on;
    // reference needs no software bit of its own
    assign ref_en_o     = s_r.det_on;
    assign threshold_o  = s_r.thr;
    assign vector_req_o = s_r.vreq;
    assign push_pc_o    = s_r.push;
    assign wake_o       = s_r.wake;
    assign irq_o        = s_r.irq;

endmodule
